// File: verilog/bmlei_pkg.sv
// Package: constants for the boot mode latch and external interrupt block
`default_nettype none
package bmlei_pkg;
  localparam int BMLEI_NUM_PINS = 4;
  localparam logic [3:0] BMLEI_MODE_RST = 4'h0;
  localparam logic [3:0] BMLEI_MASK_RST = 4'h0;
  localparam logic [3:0] BMLEI_EDGE_RST = 4'h0;
  localparam int BMLEI_SYNC_STAGES = 2;
  localparam logic [1:0] BMLEI_RST_SYNC_RST = 2'h0;
  localparam logic [1:0] BMLEI_PHASE_RST = 2'h0;
  typedef enum logic [1:0] {
    BMLEI_RUN,
    BMLEI_WAIT,
    BMLEI_STOP
  } bmlei_pwr_t;
endpackage
`default_nettype wire

// File: verilog/bmlei_top.sv
// Boot mode latch, external interrupt request front end and reset sync
`timescale 1ns/1ps
`default_nettype none
module bmlei_top
  import bmlei_pkg::*;
#(
  parameter int NUM_PINS = BMLEI_NUM_PINS
) (
  // Clock and external reset
  input wire logic clk_i,
  input wire logic reset_i,
  // Shared mode select / interrupt request pins, active low as requests
  input wire logic [NUM_PINS-1:0] boot_sel_n_i,
  // Control bits from the core
  input wire logic [NUM_PINS-1:0] irq_mask_i,
  input wire logic [NUM_PINS-1:0] irq_edge_sel_i,
  input wire logic [NUM_PINS-1:0] irq_clear_i,
  input wire logic wait_enter_i,
  input wire logic stop_enter_i,
  // Outputs to the core
  output logic [NUM_PINS-1:0] operating_mode_reg_o,
  output logic [NUM_PINS-1:0] irq_pending_o,
  output logic core_reset_o,
  output logic [1:0] phase_o,
  output logic wake_o,
  output logic in_wait_o,
  output logic in_stop_o
);
  ////////////////////////////////////////////////////////////////////////////
  // Reset release synchroniser; assertion stays asynchronous
  logic [1:0] rst_sync_ff;
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      rst_sync_ff <= BMLEI_RST_SYNC_RST;
    end else begin
      rst_sync_ff <= {rst_sync_ff[0], 1'b1};
    end
  end
  logic run;
  assign run = rst_sync_ff[1];
  assign core_reset_o = ~run;

  // Phase generator held at a fixed phase in reset for lock-step start
  logic [1:0] phase_ff;
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      phase_ff <= BMLEI_PHASE_RST;
    end else if (!run) begin
      phase_ff <= BMLEI_PHASE_RST;
    end else begin
      phase_ff <= phase_ff + 2'h1;
    end
  end
  assign phase_o = phase_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers; first stage read only by the second
  // No reset on these stages: the pins carry the mode code in reset
  logic [NUM_PINS-1:0] pin_s1_ff;
  logic [NUM_PINS-1:0] pin_s2_ff;
  logic [NUM_PINS-1:0] pin_prev_ff;
  always_ff @(posedge clk_i) begin
    pin_s1_ff <= boot_sel_n_i;
    pin_s2_ff <= pin_s1_ff;
    pin_prev_ff <= pin_s2_ff;
  end

  // Mode is zero in reset, tracks the pins from reset removal until the synchronised release, then freezes;
  // the possibly metastable first reset stage is never read here
  logic [NUM_PINS-1:0] mode_ff;
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      mode_ff <= BMLEI_MODE_RST;
    end else if (!run) begin
      mode_ff <= boot_sel_n_i;
    end
  end
  assign operating_mode_reg_o = mode_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt requests, only once out of reset
  logic [NUM_PINS-1:0] edge_hit;
  logic [NUM_PINS-1:0] edge_pend_ff;
  logic [NUM_PINS-1:0] req;
  assign edge_hit = pin_prev_ff & ~pin_s2_ff & {NUM_PINS{run}};
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      edge_pend_ff <= BMLEI_EDGE_RST;
    end else begin
      // Set wins over clear
      edge_pend_ff <= (edge_pend_ff & ~irq_clear_i) | (edge_hit & irq_edge_sel_i);
    end
  end
  // Level mode follows the pin; mask gates both kinds; trigger chosen per pin
  logic [NUM_PINS-1:0] level_req;
  assign level_req = ~pin_s2_ff & {NUM_PINS{run}};
  assign req = irq_mask_i & ((irq_edge_sel_i & edge_pend_ff) |
    (~irq_edge_sel_i & level_req));
  assign irq_pending_o = req;

  ////////////////////////////////////////////////////////////////////////////
  // Low-power state tracking and wake-up
  // Wait wins when both enter pulses arrive together
  bmlei_pwr_t pwr_ff;
  logic any_req;
  assign any_req = |req;
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      pwr_ff <= BMLEI_RUN;
    end else begin
      case (pwr_ff)
        BMLEI_RUN: begin
          if (run && wait_enter_i) begin
            pwr_ff <= BMLEI_WAIT;
          end else if (run && stop_enter_i) begin
            pwr_ff <= BMLEI_STOP;
          end
        end
        BMLEI_WAIT: begin
          if (any_req) begin
            pwr_ff <= BMLEI_RUN;
          end
        end
        BMLEI_STOP: begin
          if (any_req) begin
            pwr_ff <= BMLEI_RUN;
          end
        end
        default: begin
          pwr_ff <= BMLEI_RUN;
        end
      endcase
    end
  end
  assign in_wait_o = (pwr_ff == BMLEI_WAIT);
  assign in_stop_o = (pwr_ff == BMLEI_STOP);
  assign wake_o = (pwr_ff != BMLEI_RUN) && any_req;

  ////////////////////////////////////////////////////////////////////////////
  // Assertions
  // Edge checks watch pin 2, the pin driven in edge mode
  sequence s_pin_fall(int i);
    pin_s2_ff[i] ##1 !pin_s2_ff[i];
  endsequence
  sequence s_pin_rise(int i);
    !pin_s2_ff[i] ##1 pin_s2_ff[i];
  endsequence
  sequence s_released;
    $fell(core_reset_o);
  endsequence
  sequence s_phase_start;
    phase_o == 2'h0 ##1 phase_o == 2'h1;
  endsequence

  AST_RESET_HOLD: assert property (@(posedge clk_i) reset_i |=> core_reset_o)
    else $error("core reset not held during reset");
  AST_RELEASE_TWO: assert property (@(posedge clk_i) disable iff (reset_i)
    $fell(core_reset_o) |-> $past(rst_sync_ff[0], 1) && !$past(run, 1))
    else $error("reset release not synchronised");
  AST_PHASE_ZERO: assert property (@(posedge clk_i) disable iff (reset_i)
    core_reset_o |-> phase_o == 2'h0)
    else $error("phase generator running in reset");
  AST_MODE_STABLE: assert property (@(posedge clk_i) disable iff (reset_i)
    run && $past(run, 1) |-> $stable(operating_mode_reg_o))
    else $error("mode changed after reset release");
  AST_NO_REQ_IN_RESET: assert property (@(posedge clk_i) disable iff (reset_i)
    core_reset_o |-> (irq_pending_o == '0))
    else $error("request seen during reset");
  AST_MASKED: assert property (@(posedge clk_i) disable iff (reset_i)
    (irq_pending_o & ~irq_mask_i) == '0)
    else $error("masked request reached the core");
  AST_EDGE_PEND: assert property (@(posedge clk_i) disable iff (reset_i)
    run ##0 s_pin_fall(2) ##0 irq_edge_sel_i[2] |=> edge_pend_ff[2])
    else $error("falling edge not held pending");
  AST_WAIT_WAKE: assert property (@(posedge clk_i) disable iff (reset_i)
    in_wait_o && any_req |=> !in_wait_o)
    else $error("wait state not left on request");
  AST_STOP_WAKE: assert property (@(posedge clk_i) disable iff (reset_i)
    in_stop_o && any_req |=> !in_stop_o && !in_wait_o)
    else $error("stop state not left on request");
  AST_SYNC_DELAY: assert property (@(posedge clk_i) disable iff (reset_i)
    run && !irq_edge_sel_i[1] && irq_mask_i[1] && $past(run, 2) ##0
    !$past(boot_sel_n_i[1], 2) |-> irq_pending_o[1])
    else $error("level request not seen after two stages");
  AST_PHASE_START: assert property (@(posedge clk_i) disable iff (reset_i)
    s_released |-> s_phase_start)
    else $error("phase generator did not start from zero");
  AST_MODE_CAPTURE: assert property (@(posedge clk_i) disable iff (reset_i)
    s_released |-> operating_mode_reg_o == $past(boot_sel_n_i, 1))
    else $error("mode code not captured at release");
  AST_WAIT_ENTER: assert property (@(posedge clk_i) disable iff (reset_i)
    run && !in_wait_o && !in_stop_o && wait_enter_i |=> in_wait_o)
    else $error("wait instruction did not enter the wait state");
  AST_STOP_ENTER: assert property (@(posedge clk_i) disable iff (reset_i)
    run && !in_wait_o && !in_stop_o && !wait_enter_i && stop_enter_i |=> in_stop_o)
    else $error("stop request did not enter the stop state");
  AST_WAIT_HOLD: assert property (@(posedge clk_i) disable iff (reset_i)
    in_wait_o && !any_req |=> in_wait_o)
    else $error("wait state left without a request");
  AST_STOP_HOLD: assert property (@(posedge clk_i) disable iff (reset_i)
    in_stop_o && !any_req |=> in_stop_o)
    else $error("stop state left without a request");
  AST_CLEAR_PEND: assert property (@(posedge clk_i) disable iff (reset_i)
    irq_clear_i[2] && !edge_hit[2] |=> !edge_pend_ff[2])
    else $error("clear did not drop the pending edge");
  AST_EDGE_FALL_ONLY: assert property (@(posedge clk_i) disable iff (reset_i)
    s_pin_rise(2) ##0 !edge_pend_ff[2] |=> !edge_pend_ff[2])
    else $error("rising edge set a pending request");
endmodule
`default_nettype wire

// File: bench/bmlei_board.sv
// Board side model: reset circuitry and interrupt sources
`timescale 1ns/1ps
`default_nettype none
module bmlei_board (
  // Commands from the bench, changed only just after clock edges
  input wire logic rst_req_i,
  input wire logic [3:0] req_n_i,
  // Pins towards the device
  output logic reset_o,
  output logic [3:0] pins_o
);
  assign reset_o = rst_req_i;
  // No skew added, so requests stay in step with the clock
  assign pins_o = req_n_i;
endmodule
`default_nettype wire

// File: bench/test_boot_mode_latch_and_ext_irq.sv
// Testbench for the boot mode latch and external interrupt block
`timescale 1ns/1ps
`default_nettype none
module test_boot_mode_latch_and_ext_irq;
  import bmlei_pkg::*;
  logic clk_i = 0, rq = 1, wt = 0, st = 0, wake_o, in_wait_o, in_stop_o, core_reset_o, reset_i;
  logic [3:0] rn = 4'hA, mask = 4'h0, es = 4'h0, clr = 4'h0, pins, mode, pend;
  logic [1:0] phase_o;
  int mismatches = 0, n_checks = 0, cyc = 0;
  always #20 clk_i = ~clk_i;
  bmlei_board bmlei_board_i (.rst_req_i(rq), .req_n_i(rn), .reset_o(reset_i), .pins_o(pins));
  bmlei_top bmlei_top_i (.clk_i(clk_i), .reset_i(reset_i), .boot_sel_n_i(pins),
    .irq_mask_i(mask), .irq_edge_sel_i(es), .irq_clear_i(clr), .wait_enter_i(wt),
    .stop_enter_i(st), .operating_mode_reg_o(mode), .irq_pending_o(pend),
    .core_reset_o(core_reset_o), .phase_o(phase_o), .wake_o(wake_o),
    .in_wait_o(in_wait_o), .in_stop_o(in_stop_o));
  ////////////////////////////////////////////////////////////////////////
  task chk(input logic [3:0] seen, input logic [3:0] exp);
    n_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task close_out;
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // Mode code held on the pins through release, mask open to catch leaks
  task rst(input logic [3:0] code);
    @(posedge clk_i); rq <= 1; rn <= code; mask <= 4'hF; es <= 4'h0;
    @(posedge clk_i); #1 chk({3'h0, core_reset_o}, 4'h1);
    chk({2'h0, phase_o}, 4'h0);
    chk(pend, 4'h0);
    @(posedge clk_i); rq <= 0;
    @(posedge clk_i); #1 chk({3'h0, core_reset_o}, 4'h1);
    @(posedge clk_i); #1 chk({3'h0, core_reset_o}, 4'h0);
    chk(mode, code);
    @(posedge clk_i); rn <= 4'hF; mask <= 4'h0;
    #1 chk({2'h0, phase_o}, 4'h1);
    repeat (3) @(posedge clk_i);
  endtask
  task level;
    @(posedge clk_i); mask <= 4'h1; rn <= 4'hC;
    @(posedge clk_i); #1 chk(pend, 4'h0);
    @(posedge clk_i); #1 chk(pend, 4'h1);
    @(posedge clk_i); rn <= 4'hF;
    repeat (2) @(posedge clk_i); #1 chk(pend, 4'h0);
  endtask
  task edge_req;
    @(posedge clk_i); mask <= 4'h4; es <= 4'h4; rn <= 4'hB;
    repeat (3) @(posedge clk_i); #1 chk(pend, 4'h4);
    @(posedge clk_i); rn <= 4'hF;
    repeat (3) @(posedge clk_i); #1 chk(pend, 4'h4);
    @(posedge clk_i); clr <= 4'h4;
    @(posedge clk_i); clr <= 4'h0;
    #1 chk(pend, 4'h0);
  endtask
  task wake(input logic stp);
    @(posedge clk_i); mask <= 4'h8; es <= 4'h0; wt <= !stp; st <= stp;
    @(posedge clk_i); wt <= 0; st <= 0;
    #1 chk({2'h0, in_stop_o, in_wait_o}, stp ? 4'h2 : 4'h1);
    @(posedge clk_i); rn <= 4'h7;
    repeat (2) @(posedge clk_i); #1 chk({3'h0, wake_o}, 4'h1);
    @(posedge clk_i); #1 chk({2'h0, in_stop_o, in_wait_o}, 4'h0);
    @(posedge clk_i); rn <= 4'hF;
    repeat (3) @(posedge clk_i);
  endtask
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 2000) begin
      mismatches++;
      close_out;
    end
  end
  initial begin
    rst(4'hA);
    level;
    edge_req;
    wake(1'b0);
    wake(1'b1);
    rst(4'h5);
    close_out;
  end
endmodule
`default_nettype wire
